// ==== hw/energy_pulse_defines.vh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 10 MHz system clock
// Notes: Definitions only
`ifndef ENERGY_PULSE_DEFINES_VH
`define ENERGY_PULSE_DEFINES_VH
`define ADDR_CONFIG1 12'h0481
`define ADDR_OC_STATUS 12'h048F
`define ADDR_PULSE_MODE 12'h0490
`define ADDR_COMP_MODE 12'h0491
`define CFG1_RESET 16'h0000
`define PMODE_RESET 16'h0000
`define CMODE_RESET 16'h0000
`define OC_RESET 16'h0000
`define CFG1_DSMODE 10
`define CFG1_SETTLE_HI 9
`define CFG1_SETTLE_LO 8
`define CFG1_ACC_CLR 5
`define CFG1_PIN4_HI 3
`define CFG1_PIN4_LO 2
`define CFG1_PIN3 1
`define CFG1_SOFT_RESET_BIT 0
`define CFG1_RW_MASK 16'h870E
`define PMODE_DIS_LO 12
`define CLK_HZ 10000000
`define SETTLE_MS_0 64
`define SETTLE_MS_1 128
`define SETTLE_MS_2 256
// Settle ms times CLK_HZ / 1000, sized to the 22-bit settle counter
`define SETTLE_CYC_0 22'h09_C400
`define SETTLE_CYC_1 22'h13_8800
`define SETTLE_CYC_2 22'h27_1000
`endif

// ==== hw/sag_surge_irq.v ====
// Purpose: Dip/swell interrupt pulse generation
// Assumes: Condition and period tick come from the metrology side
// Notes: One-cycle interrupt pulse output
`timescale 1ns/10ps
module sag_surge_irq (
  input wire clk_sys_i,
  input wire reset_i,
  input wire mode_i,
  input wire cond_i,
  input wire cycle_tick_i,
  output reg irq_o
);
  reg cond_r;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      cond_r <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      cond_r <= cond_i;
      if (mode_i)
        irq_o <= cond_i ^ cond_r;
      else
        irq_o <= cond_i & cycle_tick_i;
    end
  end
endmodule // sag_surge_irq

// ==== hw/energy_pulse_config_control.v ====
// What this block does
// - Mode 0: dip/swell interrupt repeats every programmed cycle count during condition.
// - Mode 1: one interrupt on entering, one on leaving dip/swell.
// - Settle code 0/1/2/3 delays accumulation 64/128/256/0 ms.
// - Accumulation clear zeroes converter and divider counter, self-clearing.
// - Pin 4 select: 00/01 pulse, 10 event, 11 sample ready.
// - Pin 3 select: 0 pulse, 1 chosen zero-crossing signal.
// - Soft reset bit starts device reset and reads back zero.
// - Overcurrent flags: bit0 A, bit1 B, bit2 C, bit3 neutral.
// - Pulse mode bits 15..12 disable outputs 4..1; disabled pin held high.
// - Disabled output does not set its pulse status flag.
// - Bits 11..9 select pin 4 energy type; lower fields others.
// - Phase inclusion per output comes from compensation mode register.
// - Overcurrent status resets to zero and ignores writes.
// - Inclusion bit 2 phase C, bit 1 phase B, bit 0 phase A.
//
// Purpose: Configuration and status registers for energy pulse outputs
// Assumes: Host port gives a 12-bit word address, single-cycle strobes
// Notes: Metrology datapath lives outside; this block steers and gates it
`timescale 1ns/10ps
`include "energy_pulse_defines.vh"
module energy_pulse_config_control (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [11:0] host_addr_i,
  input wire host_wr_i,
  input wire host_rd_i,
  input wire [15:0] host_wdata_i,
  output reg [15:0] host_rdata_o,
  input wire [3:0] overcurrent_phase_flags_i,
  input wire [3:0] converter_pulse_i,
  input wire event_signal_i,
  input wire sample_ready_signal_i,
  input wire zero_cross_i,
  input wire sag_cond_i,
  input wire surge_cond_i,
  input wire cycle_tick_i,
  output reg energy_pulse_out_1_o,
  output reg energy_pulse_out_2_o,
  output reg energy_pulse_out_3_o,
  output reg energy_pulse_out_4_o,
  output reg [3:0] pulse_status_flag_o,
  output reg pulse_accum_clear_o,
  output reg soft_reset_o,
  output reg accum_enable_o,
  output reg [2:0] pulse_out1_energy_type_o,
  output reg [2:0] pulse_out2_energy_type_o,
  output reg [2:0] pulse_out3_energy_type_o,
  output reg [2:0] pulse_out4_energy_type_o,
  output reg [11:0] pulse_phase_include_o,
  output reg sag_irq_o,
  output reg surge_irq_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] config1_r;
  reg [15:0] pulse_output_mode_r;
  reg [15:0] compensation_mode_reg_r;
  reg [3:0] overcurrent_phase_flags_r;
  reg [3:0] oc_meta_r;
  reg [3:0] oc_sync_r;
  reg [3:0] pin_meta_r;
  reg [3:0] pin_sync_r;
  reg [3:0] misc_meta_r;
  reg [3:0] misc_sync_r;
  reg [1:0] cond_meta_r;
  reg [1:0] cond_sync_r;
  reg [3:0] pulse_prev_r;
  reg [21:0] settle_cnt_r;
  reg [21:0] settle_target;
  wire soft_clear;
  wire sag_irq;
  wire surge_irq;
  wire [1:0] settle_code;
  wire [1:0] pin4_fn;
  wire pin3_fn;
  wire [3:0] out_disable;
  wire [3:0] pulse_rise;

  assign settle_code = config1_r[`CFG1_SETTLE_HI:`CFG1_SETTLE_LO];
  assign pin4_fn = config1_r[`CFG1_PIN4_HI:`CFG1_PIN4_LO];
  assign pin3_fn = config1_r[`CFG1_PIN3];
  assign out_disable = pulse_output_mode_r[15:`PMODE_DIS_LO];
  assign pulse_rise = pin_sync_r & ~pulse_prev_r;
  // Soft reset acts one cycle after the write so the write itself completes
  assign soft_clear = reset_i | soft_reset_o;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      oc_meta_r <= 4'h0;
      oc_sync_r <= 4'h0;
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
      misc_meta_r <= 4'h0;
      misc_sync_r <= 4'h0;
      cond_meta_r <= 2'b00;
      cond_sync_r <= 2'b00;
      pulse_prev_r <= 4'h0;
    end else begin
      oc_meta_r <= overcurrent_phase_flags_i;
      oc_sync_r <= oc_meta_r;
      pin_meta_r <= converter_pulse_i;
      pin_sync_r <= pin_meta_r;
      misc_meta_r <= {event_signal_i, sample_ready_signal_i, zero_cross_i, cycle_tick_i};
      misc_sync_r <= misc_meta_r;
      cond_meta_r <= {surge_cond_i, sag_cond_i};
      cond_sync_r <= cond_meta_r;
      pulse_prev_r <= pin_sync_r;
    end
  end

  // ----------------------------------------
  // Host writes
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (soft_clear) begin
      config1_r <= `CFG1_RESET;
      pulse_output_mode_r <= `PMODE_RESET;
      compensation_mode_reg_r <= `CMODE_RESET;
      pulse_accum_clear_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      pulse_accum_clear_o <= 1'b0;
      soft_reset_o <= 1'b0;
      if (host_wr_i) begin
        if (host_addr_i == `ADDR_CONFIG1) begin
          config1_r <= host_wdata_i & `CFG1_RW_MASK;
          pulse_accum_clear_o <= host_wdata_i[`CFG1_ACC_CLR];
          soft_reset_o <= host_wdata_i[`CFG1_SOFT_RESET_BIT];
        end else if (host_addr_i == `ADDR_PULSE_MODE) begin
          pulse_output_mode_r <= host_wdata_i;
        end else if (host_addr_i == `ADDR_COMP_MODE) begin
          compensation_mode_reg_r <= {4'h0, host_wdata_i[11:0]};
        end
      end
    end
  end

  // Overcurrent status follows the phase flags; writes are ignored
  always @(posedge clk_sys_i) begin
    if (soft_clear)
      overcurrent_phase_flags_r <= 4'h0;
    else
      overcurrent_phase_flags_r <= oc_sync_r;
  end

  // ----------------------------------------
  // Host reads
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      host_rdata_o <= 16'h0000;
    end else if (host_rd_i) begin
      if (host_addr_i == `ADDR_CONFIG1)
        host_rdata_o <= config1_r;
      else if (host_addr_i == `ADDR_OC_STATUS)
        host_rdata_o <= {12'h000, overcurrent_phase_flags_r};
      else if (host_addr_i == `ADDR_PULSE_MODE)
        host_rdata_o <= pulse_output_mode_r;
      else if (host_addr_i == `ADDR_COMP_MODE)
        host_rdata_o <= compensation_mode_reg_r;
      else
        host_rdata_o <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Settling delay before accumulation
  // ----------------------------------------
  always @* begin
    case (settle_code)
      2'd0: settle_target = `SETTLE_CYC_0;
      2'd1: settle_target = `SETTLE_CYC_1;
      2'd2: settle_target = `SETTLE_CYC_2;
      default: settle_target = 22'h00_0000;
    endcase
  end

  // Restarted by any reset or accumulation clear; a settle change applies at once until accumulation is enabled, then only on restart
  always @(posedge clk_sys_i) begin
    if (soft_clear || pulse_accum_clear_o) begin
      settle_cnt_r <= 22'h00_0000;
      accum_enable_o <= 1'b0;
    end else if (settle_cnt_r >= settle_target) begin
      accum_enable_o <= 1'b1;
    end else begin
      settle_cnt_r <= settle_cnt_r + 22'h00_0001;
    end
  end

  // ----------------------------------------
  // Pin muxing, disables and status flags
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (soft_clear) begin
      energy_pulse_out_1_o <= 1'b1;
      energy_pulse_out_2_o <= 1'b1;
      energy_pulse_out_3_o <= 1'b1;
      energy_pulse_out_4_o <= 1'b1;
    end else begin
      energy_pulse_out_1_o <= out_disable[0] | pin_sync_r[0];
      energy_pulse_out_2_o <= out_disable[1] | pin_sync_r[1];
      if (out_disable[2])
        energy_pulse_out_3_o <= 1'b1;
      else if (pin3_fn)
        energy_pulse_out_3_o <= misc_sync_r[1];
      else
        energy_pulse_out_3_o <= pin_sync_r[2];
      if (out_disable[3])
        energy_pulse_out_4_o <= 1'b1;
      else if (pin4_fn == 2'b10)
        energy_pulse_out_4_o <= misc_sync_r[3];
      else if (pin4_fn == 2'b11)
        energy_pulse_out_4_o <= misc_sync_r[2];
      else
        energy_pulse_out_4_o <= pin_sync_r[3];
    end
  end

  always @(posedge clk_sys_i) begin
    if (soft_clear)
      pulse_status_flag_o <= 4'h0;
    else
      pulse_status_flag_o <= pulse_rise & ~out_disable & {4{accum_enable_o}};
  end

  always @(posedge clk_sys_i) begin
    if (soft_clear) begin
      pulse_out1_energy_type_o <= 3'h0;
      pulse_out2_energy_type_o <= 3'h0;
      pulse_out3_energy_type_o <= 3'h0;
      pulse_out4_energy_type_o <= 3'h0;
      pulse_phase_include_o <= 12'h000;
    end else begin
      // Codes 110/111 fold to total active
      pulse_out1_energy_type_o <= pulse_output_mode_r[2:1] == 2'b11 ? 3'h0 :
                                  pulse_output_mode_r[2:0];
      pulse_out2_energy_type_o <= pulse_output_mode_r[5:4] == 2'b11 ? 3'h0 :
                                  pulse_output_mode_r[5:3];
      pulse_out3_energy_type_o <= pulse_output_mode_r[8:7] == 2'b11 ? 3'h0 :
                                  pulse_output_mode_r[8:6];
      pulse_out4_energy_type_o <= pulse_output_mode_r[11:10] == 2'b11 ? 3'h0 :
                                  pulse_output_mode_r[11:9];
      pulse_phase_include_o <= compensation_mode_reg_r[11:0];
    end
  end

  // ----------------------------------------
  // Dip/swell interrupts
  // ----------------------------------------
  sag_surge_irq u_sag_irq (
    .clk_sys_i(clk_sys_i),
    .reset_i(soft_clear),
    .mode_i(config1_r[`CFG1_DSMODE]),
    .cond_i(cond_sync_r[0]),
    .cycle_tick_i(misc_sync_r[0]),
    .irq_o(sag_irq)
  );

  sag_surge_irq u_surge_irq (
    .clk_sys_i(clk_sys_i),
    .reset_i(soft_clear),
    .mode_i(config1_r[`CFG1_DSMODE]),
    .cond_i(cond_sync_r[1]),
    .cycle_tick_i(misc_sync_r[0]),
    .irq_o(surge_irq)
  );

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sag_irq_o <= 1'b0;
      surge_irq_o <= 1'b0;
    end else begin
      sag_irq_o <= sag_irq;
      surge_irq_o <= surge_irq;
    end
  end
endmodule // energy_pulse_config_control

// ==== testbench/energy_pulse_checker_asserts.sv ====
// Purpose: Port-level checks of the energy pulse register block
// Assumes: One-cycle host strobes, inputs held steady between changes
// Notes: Config fields are shadowed from host writes
`timescale 1ns/10ps
module energy_pulse_checker (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [11:0] host_addr_i,
  input wire host_wr_i,
  input wire host_rd_i,
  input wire [15:0] host_wdata_i,
  input wire [15:0] host_rdata_o,
  input wire [3:0] overcurrent_phase_flags_i,
  input wire [3:0] converter_pulse_i,
  input wire event_signal_i,
  input wire sample_ready_signal_i,
  input wire zero_cross_i,
  input wire sag_cond_i,
  input wire energy_pulse_out_3_o,
  input wire energy_pulse_out_4_o,
  input wire [3:0] pulse_status_flag_o,
  input wire pulse_accum_clear_o,
  input wire soft_reset_o,
  input wire [2:0] pulse_out4_energy_type_o,
  input wire sag_irq_o
);
  // ----------------------------------------
  // Shadow of host fields
  // ----------------------------------------
  reg [15:0] cfg_r;
  reg [15:0] pm_r;
  wire cw = host_wr_i && host_addr_i == 12'h0481;
  wire [1:0] f4 = cfg_r[3:2];
  // Resets sit in the window so pins are judged only once the synchronisers settle
  wire [28:0] stab = {cfg_r, pm_r[15:12], converter_pulse_i, event_signal_i,
    sample_ready_signal_i, zero_cross_i, soft_reset_o, reset_i};
  always @(posedge clk_sys_i) begin
    if (reset_i || soft_reset_o) begin
      cfg_r <= 16'h0000;
      pm_r <= 16'h0000;
    end else if (host_wr_i) begin
      if (host_addr_i == 12'h0481)
        cfg_r <= host_wdata_i;
      if (host_addr_i == 12'h0490)
        pm_r <= host_wdata_i;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_steady; $stable(stab)[*5]; endsequence
  sequence s_oc_read;
    $stable(overcurrent_phase_flags_i)[*4] ##0 host_rd_i && host_addr_i == 12'h048F; endsequence
  sequence s_enter; cfg_r[10] && $rose(sag_cond_i); endsequence
  property p_pin4;
    s_steady |-> energy_pulse_out_4_o == (pm_r[15] | (f4 == 2'b10 ? event_signal_i :
      f4 == 2'b11 ? sample_ready_signal_i : converter_pulse_i[3])); endproperty
  a_pin4: assert property (p_pin4) else $error("pin 4 level");
  property p_pin3;
    s_steady |-> energy_pulse_out_3_o == (pm_r[14] |
      (cfg_r[1] ? zero_cross_i : converter_pulse_i[2])); endproperty
  a_pin3: assert property (p_pin3) else $error("pin 3 level");
  property p_type4;
    $stable({pm_r, soft_reset_o, reset_i})[*3] |->
      pulse_out4_energy_type_o == (pm_r[11:9] > 3'h5 ? 3'h0 : pm_r[11:9]); endproperty
  a_type4: assert property (p_type4) else $error("pin 4 type");
  property p_clr;
    cw && host_wdata_i[5] |=> pulse_accum_clear_o ##1 !pulse_accum_clear_o; endproperty
  a_clr: assert property (p_clr) else $error("accum clear pulse");
  property p_soft_reset_bit;
    cw && host_wdata_i[0] |=> soft_reset_o ##1 !soft_reset_o; endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset pulse");
  property p_oc;
    s_oc_read |=> host_rdata_o == {12'h000, $past(overcurrent_phase_flags_i)}; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent read");
  property p_flag_gate;
    !(|(pulse_status_flag_o & $past(pm_r[15:12]))); endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("flag while disabled");
  property p_sag_edge; s_enter |-> ##[1:8] sag_irq_o; endproperty
  a_sag_edge: assert property (p_sag_edge) else $error("no entry interrupt");
endmodule // energy_pulse_checker
bind energy_pulse_config_control energy_pulse_checker chk_u (.*);

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the energy pulse register block
// Assumes: Settle code 3 gives a quick accumulation start
// Notes: Reads are scored from a queue of expected words
`timescale 1ns/10ps
module tb;
  reg clk_sys_i = 1'b0, reset_i = 1'b1, host_wr_i = 1'b0, host_rd_i = 1'b0, rd_d = 1'b0;
  reg event_signal_i = 1'b0, sample_ready_signal_i = 1'b0, zero_cross_i = 1'b0, e4 = 1'b0;
  reg sag_cond_i = 1'b0, surge_cond_i = 1'b0, cycle_tick_i = 1'b0;
  reg [11:0] host_addr_i = 12'h000;
  reg [15:0] host_wdata_i = 16'h0000, v = 16'h0000;
  reg [3:0] overcurrent_phase_flags_i = 4'h0, converter_pulse_i = 4'h0, fl = 4'h0;
  reg [15:0] rq[$];
  integer miscompares = 0, samples_checked = 0, sag_n = 0, surge_n = 0, i;
  wire [15:0] host_rdata_o;
  wire energy_pulse_out_1_o, energy_pulse_out_2_o, energy_pulse_out_3_o, energy_pulse_out_4_o;
  wire [3:0] pulse_status_flag_o;
  wire pulse_accum_clear_o, soft_reset_o, accum_enable_o, sag_irq_o, surge_irq_o;
  wire [2:0] pulse_out1_energy_type_o, pulse_out2_energy_type_o;
  wire [2:0] pulse_out3_energy_type_o, pulse_out4_energy_type_o;
  wire [11:0] pulse_phase_include_o;
  wire [3:0] pins = {energy_pulse_out_4_o, energy_pulse_out_3_o, energy_pulse_out_2_o,
    energy_pulse_out_1_o};
  energy_pulse_config_control dut_u (.*);
  // ----------------------------------------
  // Host access and scoring
  // ----------------------------------------
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Energy type decode: codes above fundamental apparent fold to total active
  function [2:0] et(input [2:0] c);
    et = (c > 3'h5) ? 3'h0 : c;
  endfunction
  // One task for both strobes keeps reads and writes on identical timing
  task acc(input w, input [11:0] a, input [15:0] d);
    begin
      if (!w)
        rq.push_back(d);
      @(posedge clk_sys_i);
      #1 host_addr_i = a;
      host_wdata_i = d;
      host_wr_i = w;
      host_rd_i = !w;
      @(posedge clk_sys_i);
      #1 host_wr_i = 1'b0;
      host_rd_i = 1'b0;
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) rd_d <= host_rd_i;
  always @(negedge clk_sys_i) begin
    if (rd_d)
      chk("read data", rq.pop_front(), host_rdata_o);
    if (sag_irq_o === 1'b1)
      sag_n = sag_n + 1;
    if (surge_irq_o === 1'b1)
      surge_n = surge_n + 1;
  end
  initial begin
    #3000000 miscompares = miscompares + 1;
    stop_test;
  end
  initial begin
    v = $urandom(94110);
    #151 reset_i = 1'b0;
    chk("pins", 16'h000f, {12'h000, pins});
    acc(0, 12'h0490, 16'h0000);
    acc(0, 12'h0123, 16'h0000);
    v = $urandom;
    overcurrent_phase_flags_i = v[3:0];
    acc(1, 12'h048F, 16'hffff);
    #400 acc(0, 12'h048F, {12'h000, v[3:0]});
    for (i = 0; i < 4; i = i + 1) begin
      v = $urandom;
      acc(1, 12'h0481, v & 16'hfffe);
      acc(1, 12'h0490, v);
      acc(1, 12'h0491, ~v);
      acc(0, 12'h0481, v & 16'h870e);
      acc(0, 12'h0490, v);
      acc(0, 12'h0491, ~v & 16'h0fff);
      chk("phase include", ~v & 16'h0fff, {4'h0, pulse_phase_include_o});
      chk("energy types", {4'h0, et(v[11:9]), et(v[8:6]), et(v[5:3]), et(v[2:0])},
        {4'h0, pulse_out4_energy_type_o, pulse_out3_energy_type_o, pulse_out2_energy_type_o,
        pulse_out1_energy_type_o});
    end
    for (i = 0; i < 16; i = i + 1) begin
      acc(1, 12'h0481, {12'h030, i[1:0], i[2], 1'b0});
      acc(1, 12'h0490, {i[3], 15'h0000});
      v = $urandom;
      {converter_pulse_i, event_signal_i, sample_ready_signal_i, zero_cross_i} = v[6:0];
      #600 e4 = i[1:0] == 2 ? event_signal_i : i[1:0] == 3 ? sample_ready_signal_i :
        converter_pulse_i[3];
      chk("pins", {12'h000, e4 | i[3], i[2] ? zero_cross_i : converter_pulse_i[2],
        converter_pulse_i[1:0]}, {12'h000, pins});
    end
    acc(1, 12'h0481, 16'h0320);
    acc(1, 12'h0490, 16'ha000);
    converter_pulse_i = 4'h0;
    #800 chk("accum enable", 16'h0001, {15'h0000, accum_enable_o});
    converter_pulse_i = 4'hf;
    repeat (8) @(negedge clk_sys_i) fl = fl | pulse_status_flag_o;
    chk("status flags", 16'h0005, {12'h000, fl});
    acc(1, 12'h0481, 16'h0700);
    #400 sag_cond_i = 1'b1;
    #1200 sag_cond_i = 1'b0;
    #1200 chk("sag irq count", 16'h0002, sag_n[15:0]);
    acc(1, 12'h0481, 16'h0300);
    surge_cond_i = 1'b1;
    repeat (3) begin
      #1000 cycle_tick_i = 1'b1;
      #100 cycle_tick_i = 1'b0;
    end
    #1000 surge_cond_i = 1'b0;
    #1000 chk("surge irq count", 16'h0003, surge_n[15:0]);
    acc(1, 12'h0490, 16'hf000);
    acc(1, 12'h0481, 16'h0001);
    #400 acc(0, 12'h0490, 16'h0000);
    acc(0, 12'h0481, 16'h0000);
    acc(0, 12'h0491, 16'h0000);
    #100000 chk("accum enable", 16'h0000, {15'h0000, accum_enable_o});
    stop_test;
  end
endmodule // tb
